/* rtl/period_match_timer8.sv */
`timescale 1ns/10ps
`default_nettype none
module period_match_timer8 (
   input wire logic mclk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   output logic [7:0] pwmCount,
   output logic periodMatch
);
   import period_timer_pkg::*;

   logic [7:0] countValue_ff;
   logic [7:0] periodLimit_ff;
   logic [6:0] tickControl_ff;
   logic [1:0] flagReg_ff;
   logic [1:0] maskReg_ff;
   logic [1:0] instrDiv_ff;
   logic [3:0] preCount_ff;
   logic [3:0] postCount_ff;
   logic [7:0] nxt_countValue;
   logic instrTick;
   logic countTick;
   logic matchNow;
   logic postEvent;
   logic countWrite;
   logic wrapStep;
   logic accessCycle;
   logic wrCount;
   logic wrControl;
   logic wrPeriod;
   logic wrFlag;
   logic wrMask;
   logic [3:0] preLast;
   apb_state_type apbState_ff;

   function automatic logic [3:0] pre_last(input logic [1:0] sel);
      if (sel == 2'b00) begin
         pre_last = 4'h0;
      end else if (sel == 2'b01) begin
         pre_last = DIV4_LAST;
      end else begin
         pre_last = DIV16_LAST;
      end
   endfunction

   // Bus decode; slave answers in the first access cycle
   assign accessCycle = psel && penable;
   assign wrCount = accessCycle && pwrite && (paddr == COUNT_OFS);
   assign wrControl = accessCycle && pwrite && (paddr == CONTROL_OFS);
   assign wrPeriod = accessCycle && pwrite && (paddr == PERIOD_OFS);
   assign wrFlag = accessCycle && pwrite && (paddr == FLAG_OFS);
   assign wrMask = accessCycle && pwrite && (paddr == MASK_OFS);

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         apbState_ff <= APB_IDLE;
      end else begin
         case (apbState_ff)
            APB_IDLE: begin
               if (psel && !penable) begin
                  apbState_ff <= APB_SETUP;
               end
            end
            APB_SETUP: begin
               apbState_ff <= APB_ACCESS;
            end
            APB_ACCESS: begin
               apbState_ff <= (psel && !penable) ? APB_SETUP : APB_IDLE;
            end
            default: begin
               apbState_ff <= APB_IDLE;
            end
         endcase
      end
   end

   // Combinational pready would break the flop-output style, so registered
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         if (psel && !penable && !pwrite) begin
            if (paddr == COUNT_OFS) begin
               prdata <= {24'h000000, countValue_ff};
            end else if (paddr == CONTROL_OFS) begin
               prdata <= {24'h000000, 1'b0, tickControl_ff};
            end else if (paddr == PERIOD_OFS) begin
               prdata <= {24'h000000, periodLimit_ff};
            end else if (paddr == FLAG_OFS) begin
               prdata <= {30'h00000000, flagReg_ff};
            end else if (paddr == MASK_OFS) begin
               prdata <= {30'h00000000, maskReg_ff};
            end else begin
               prdata <= 32'h00000000;
               pslverr <= 1'b1;
            end
         end else if (psel && !penable) begin
            pslverr <= !(paddr == COUNT_OFS || paddr == CONTROL_OFS || paddr == PERIOD_OFS
                         || paddr == FLAG_OFS || paddr == MASK_OFS);
         end
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         tickControl_ff <= CONTROL_RESET;
      end else if (wrControl && pready) begin
         tickControl_ff <= pwdata[6:0];
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         periodLimit_ff <= PERIOD_RESET;
      end else if (wrPeriod && pready) begin
         periodLimit_ff <= pwdata[7:0];
      end
   end

   // Instruction clock enable, a quarter of mclk
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         instrDiv_ff <= 2'h0;
      end else begin
         instrDiv_ff <= instrDiv_ff + 2'h1;
      end
   end
   assign instrTick = (instrDiv_ff == INSTR_DIV);

   assign preLast = pre_last(tickControl_ff[1:0]);
   assign countTick = instrTick && tickControl_ff[RUN_BIT] && (preCount_ff >= preLast);
   assign matchNow = (countValue_ff == periodLimit_ff);
   // A count write on the wrap step wins, so that wrap is never reported
   assign countWrite = wrCount && pready;
   assign wrapStep = countTick && matchNow && !countWrite;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         preCount_ff <= 4'h0;
      end else if ((wrCount || wrControl) && pready) begin
         preCount_ff <= 4'h0;
      end else if (instrTick && tickControl_ff[RUN_BIT]) begin
         preCount_ff <= countTick ? 4'h0 : preCount_ff + 4'h1;
      end
   end

   always_comb begin
      nxt_countValue = countValue_ff;
      if (countWrite) begin
         nxt_countValue = pwdata[7:0];
      end else if (countTick) begin
         nxt_countValue = matchNow ? COUNT_RESET : countValue_ff + 8'h01;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         countValue_ff <= COUNT_RESET;
      end else begin
         countValue_ff <= nxt_countValue;
      end
   end

   assign postEvent = wrapStep && (postCount_ff == tickControl_ff[6:3]);

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         postCount_ff <= 4'h0;
      end else if ((wrCount || wrControl) && pready) begin
         postCount_ff <= 4'h0;
      end else if (wrapStep) begin
         postCount_ff <= postEvent ? 4'h0 : postCount_ff + 4'h1;
      end
   end

   // Set beats a same-cycle write-one clear
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         flagReg_ff <= 2'b00;
      end else begin
         flagReg_ff[0] <= 1'b0;
         if (postEvent) begin
            flagReg_ff[FLAG_BIT] <= 1'b1;
         end else if (wrFlag && pready && pwdata[FLAG_BIT]) begin
            flagReg_ff[FLAG_BIT] <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         maskReg_ff <= 2'b00;
      end else if (wrMask && pready) begin
         maskReg_ff <= {pwdata[FLAG_BIT], 1'b0};
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         irq <= 1'b0;
      end else begin
         irq <= |(flagReg_ff & maskReg_ff);
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         pwmCount <= COUNT_RESET;
         periodMatch <= 1'b0;
      end else begin
         pwmCount <= nxt_countValue;
         periodMatch <= wrapStep;
      end
   end

   property p_wrap;
      @(posedge mclk) disable iff (reset) wrapStep |=> countValue_ff == 8'h00;
   endproperty
   a_wrap: assert property (p_wrap) else $error("count did not wrap at period");

   property p_step;
      @(posedge mclk) disable iff (reset) countTick && !matchNow && !(wrCount && pready)
         |=> countValue_ff == $past(countValue_ff) + 8'h01;
   endproperty
   a_step: assert property (p_step) else $error("count did not step");

   property p_stopped;
      @(posedge mclk) disable iff (reset) !tickControl_ff[RUN_BIT] && !(wrCount && pready)
         |=> $stable(countValue_ff);
   endproperty
   a_stopped: assert property (p_stopped) else $error("count moved while stopped");

   property p_ctrlkeep;
      @(posedge mclk) disable iff (reset) wrControl && pready && !countTick |=> $stable(countValue_ff);
   endproperty
   a_ctrlkeep: assert property (p_ctrlkeep) else $error("control write changed count");

   property p_clear;
      @(posedge mclk) disable iff (reset) (wrCount || wrControl) && pready
         |=> preCount_ff == 4'h0 && postCount_ff == 4'h0;
   endproperty
   a_clear: assert property (p_clear) else $error("scalers not cleared");

   property p_flagset;
      @(posedge mclk) disable iff (reset) postEvent |=> flagReg_ff[FLAG_BIT] ##1 irq == $past(maskReg_ff[FLAG_BIT]);
   endproperty
   a_flagset: assert property (p_flagset) else $error("event flag or irq wrong");

   property p_flaghold;
      @(posedge mclk) disable iff (reset) flagReg_ff[FLAG_BIT] && !(wrFlag && pready && pwdata[FLAG_BIT])
         |=> flagReg_ff[FLAG_BIT];
   endproperty
   a_flaghold: assert property (p_flaghold) else $error("event flag dropped");

   property p_div16;
      @(posedge mclk) disable iff (reset) preCount_ff <= preLast;
   endproperty
   a_div16: assert property (p_div16) else $error("prescaler out of range");

   property p_tickspacing;
      @(posedge mclk) disable iff (reset) instrTick |=> !instrTick [*3] ##1 instrTick;
   endproperty
   a_tickspacing: assert property (p_tickspacing) else $error("instruction tick spacing wrong");

   property p_match;
      @(posedge mclk) disable iff (reset) periodMatch |-> pwmCount == 8'h00;
   endproperty
   a_match: assert property (p_match) else $error("match pulse without wrap");

   property p_bit7;
      @(posedge mclk) disable iff (reset) pready && paddr == CONTROL_OFS && !pwrite |-> prdata[7] == 1'b0;
   endproperty
   a_bit7: assert property (p_bit7) else $error("control bit 7 not zero");

   property p_apbstate;
      @(posedge mclk) disable iff (reset) pready |-> apbState_ff == APB_SETUP;
   endproperty
   a_apbstate: assert property (p_apbstate) else $error("ready outside the access cycle");

   property p_refused;
      @(posedge mclk) disable iff (reset) pslverr && !pwrite |-> pready && prdata == 32'h00000000;
   endproperty
   a_refused: assert property (p_refused) else $error("refused read returned data");

   property p_countwr;
      @(posedge mclk) disable iff (reset) countWrite |=> countValue_ff == $past(pwdata[7:0]);
   endproperty
   a_countwr: assert property (p_countwr) else $error("count write lost");

   property p_ctrlwr;
      @(posedge mclk) disable iff (reset) wrControl && pready |=> tickControl_ff == $past(pwdata[6:0]);
   endproperty
   a_ctrlwr: assert property (p_ctrlwr) else $error("control write lost");

   property p_periodwr;
      @(posedge mclk) disable iff (reset) wrPeriod && pready |=> periodLimit_ff == $past(pwdata[7:0]);
   endproperty
   a_periodwr: assert property (p_periodwr) else $error("period write lost");

   property p_pwmcopy;
      @(posedge mclk) disable iff (reset) pwmCount == countValue_ff;
   endproperty
   a_pwmcopy: assert property (p_pwmcopy) else $error("time base copy differs from count");

   property p_matchonce;
      @(posedge mclk) disable iff (reset) periodMatch |=> !periodMatch;
   endproperty
   a_matchonce: assert property (p_matchonce) else $error("match pulse longer than one cycle");

   property p_posthold;
      @(posedge mclk) disable iff (reset) postCount_ff <= tickControl_ff[6:3];
   endproperty
   a_posthold: assert property (p_posthold) else $error("postscaler past its limit");

   property p_div1;
      @(posedge mclk) disable iff (reset) tickControl_ff[1:0] == 2'b00
         |-> countTick == (instrTick && tickControl_ff[RUN_BIT]);
   endproperty
   a_div1: assert property (p_div1) else $error("undivided count missed a tick");

   property p_flagclear;
      @(posedge mclk) disable iff (reset) wrFlag && pready && pwdata[FLAG_BIT] && !postEvent
         |=> !flagReg_ff[FLAG_BIT];
   endproperty
   a_flagclear: assert property (p_flagclear) else $error("event flag not cleared");

   property p_irqlevel;
      @(posedge mclk) disable iff (reset) 1'b1
         |=> irq == $past(flagReg_ff[FLAG_BIT] && maskReg_ff[FLAG_BIT]);
   endproperty
   a_irqlevel: assert property (p_irqlevel) else $error("interrupt level wrong");
endmodule
`default_nettype wire

/* shared/period_timer_pkg.sv */
// Summary of operation
// - Count climbs from 00h to the period value, then returns to 00h next step.
// - Reset loads the period register with all ones.
// - Count steps on the instruction clock (mclk divided by four) after the prescaler.
// - Input divide field bits 1-0: 00 by 1, 01 by 4, 1x by 16.
// - Match divide field bits 6-3 gives postscale 1:1 up to 1:16.
// - Each postscaler event sets the period event flag, status bit 1.
// - Count write, control write or reset clears both scaler counters.
// - A control write leaves the count unchanged.
// - Count register is read/write and resets to zero.
// - Control bit 2 runs the timer; clear stops it.
// - Control bit 7 reads zero and ignores writes.
// - Raw period match is offered to the serial port as a pulse.
// - Count and period match are offered to the PWM unit.
// - Control register resets to zero.
package period_timer_pkg;
   localparam logic [11:0] COUNT_OFS = 12'h000;
   localparam logic [11:0] CONTROL_OFS = 12'h004;
   localparam logic [11:0] PERIOD_OFS = 12'h008;
   localparam logic [11:0] FLAG_OFS = 12'h00C;
   localparam logic [11:0] MASK_OFS = 12'h010;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] PERIOD_RESET = 8'hFF;
   localparam logic [6:0] CONTROL_RESET = 7'h00;
   localparam int RUN_BIT = 2;
   localparam int FLAG_BIT = 1;
   localparam logic [1:0] INSTR_DIV = 2'h3;
   localparam logic [3:0] DIV4_LAST = 4'h3;
   localparam logic [3:0] DIV16_LAST = 4'hF;
   typedef enum logic [1:0] {
      APB_IDLE = 2'b00,
      APB_SETUP = 2'b01,
      APB_ACCESS = 2'b11
   } apb_state_type;
endpackage

/* testbench/match_listener.sv */
`timescale 1ns/10ps
`default_nettype none
module match_listener (
   input wire logic mclk,
   input wire logic reset,
   input wire logic periodMatch,
   output logic [15:0] matchCount
);
   // Stands in for the serial port and PWM side; only counts raw matches
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         matchCount <= 16'h0000;
      end else if (periodMatch === 1'b1) begin
         matchCount <= matchCount + 16'h0001;
      end
   end
endmodule
`default_nettype wire

/* testbench/tb_period_match_timer8.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_period_match_timer8;
   import period_timer_pkg::*;
   logic mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, periodMatch, errSeen;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [7:0] pwmCount;
   logic [15:0] matchCount, mBefore;
   int n_mismatch = 0, num_checks = 0, gap;
   int preDiv[4] = '{1, 4, 16, 16};
   initial begin
      forever #12.5 mclk = ~mclk;
   end
   period_match_timer8 u_period_match_timer8 (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq(irq), .pwmCount(pwmCount), .periodMatch(periodMatch));
   match_listener u_match_listener (.mclk(mclk), .reset(reset), .periodMatch(periodMatch),
      .matchCount(matchCount));
   task conclude;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task timeout;
      n_mismatch++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, 32'h0, 32'h1);
      conclude;
   endtask
   // Called just after an edge; holds the request until pready is sampled
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge mclk);
         if (pready === 1'b1) break;
      end
      if (i == 20) timeout;
      rd = prdata;
      errSeen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   task rdchk(input logic [11:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      check(rd, exp);
   endtask
   // Gap is the edge count since the previous call returned
   task waitMatch;
      int i;
      for (i = 0; i < 1100; i++) begin
         @(posedge mclk);
         if (periodMatch === 1'b1) break;
      end
      if (i == 1100) timeout;
      gap = i + 1;
   endtask
   initial begin
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      rdchk(COUNT_OFS, 32'h0);
      rdchk(CONTROL_OFS, 32'h0);
      rdchk(PERIOD_OFS, 32'h0000_00FF);
      rdchk(12'h020, 32'h0);
      check({31'h0, errSeen}, 32'h1);
      xfer(1'b1, CONTROL_OFS, 32'h0000_00F8);
      rdchk(CONTROL_OFS, 32'h0000_0078);
      xfer(1'b1, COUNT_OFS, 32'h0000_0005);
      repeat (40) @(posedge mclk);
      rdchk(COUNT_OFS, 32'h0000_0005);
      check({24'h0, pwmCount}, 32'h0000_0005);
      xfer(1'b1, CONTROL_OFS, 32'h0);
      rdchk(COUNT_OFS, 32'h0000_0005);
      $display("register test done");
      xfer(1'b1, PERIOD_OFS, 32'h0000_0003);
      xfer(1'b1, COUNT_OFS, 32'h0);
      for (int p = 0; p < 4; p++) begin
         xfer(1'b1, CONTROL_OFS, 32'h4 | p);
         waitMatch;
         waitMatch;
         check(gap, 16 * preDiv[p]);
         check({24'h0, pwmCount}, 32'h0);
      end
      $display("period test done");
      xfer(1'b1, MASK_OFS, 32'h2);
      for (int q = 0; q < 16; q++) begin
         xfer(1'b1, CONTROL_OFS, 32'h0);
         xfer(1'b1, FLAG_OFS, 32'h2);
         xfer(1'b1, COUNT_OFS, 32'h0);
         mBefore = matchCount;
         xfer(1'b1, CONTROL_OFS, (q << 3) | 32'h4);
         for (gap = 0; gap < 600 && irq !== 1'b1; gap++) @(posedge mclk);
         if (gap == 600) timeout;
         check(matchCount - mBefore, q + 1);
         rdchk(FLAG_OFS, 32'h2);
      end
      waitMatch;
      waitMatch;
      rdchk(FLAG_OFS, 32'h2);
      xfer(1'b1, MASK_OFS, 32'h0);
      repeat (2) @(posedge mclk);
      check({31'h0, irq}, 32'h0);
      xfer(1'b1, CONTROL_OFS, 32'h0);
      xfer(1'b1, FLAG_OFS, 32'h2);
      rdchk(FLAG_OFS, 32'h0);
      $display("event test done");
      // A stale prescaler would step the count well before the read
      xfer(1'b1, CONTROL_OFS, 32'h6);
      repeat (40) @(posedge mclk);
      xfer(1'b1, COUNT_OFS, 32'h0);
      repeat (40) @(posedge mclk);
      rdchk(COUNT_OFS, 32'h0);
      $display("scaler clear test done");
      conclude;
   end
endmodule
`default_nettype wire
